// ===== pkg/csf_pkg.sv
// Package for the processor status word block: offsets, field positions, reset values.
// Assumes an AXI4-Lite master with 32-bit data and one aligned word per register.
package csf_pkg;
  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h10;
  localparam int ADDR_W = 8;

  // ****************************************
  // Status word field positions
  // ****************************************
  localparam int BIT_OVF_A = 15;
  localparam int BIT_OVF_B = 14;
  localparam int BIT_CLIP_A = 13;
  localparam int BIT_CLIP_B = 12;
  localparam int BIT_ANY_OVF = 11;
  localparam int BIT_ANY_CLIP = 10;
  localparam int BIT_LOOP = 9;
  localparam int BIT_HALF_CARRY = 8;
  localparam int BIT_PRIO_HI = 7;
  localparam int BIT_PRIO_LO = 5;
  localparam int BIT_REPEAT = 4;
  localparam int BIT_ALU_LO = 0;
  localparam int BIT_ALU_HI = 3;

  // Core control: fourth priority bit; interrupt control: nesting disable
  localparam int BIT_CORE_PRIO3 = 3;
  localparam int BIT_NEST_DIS = 15;

  // Event status bits
  localparam int EVT_OVF_A = 0;
  localparam int EVT_OVF_B = 1;
  localparam int EVT_CLIP_A = 2;
  localparam int EVT_CLIP_B = 3;
  localparam int EVT_W = 4;

  // ****************************************
  // Reset values and responses
  // ****************************************
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== verilog/csf_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a single clock with synchronous active-low reset.
`timescale 1ns/1ps
module csf_axil_slave
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [csf_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // Write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Read address and data
  input wire logic [csf_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register side
  output logic wr_en,
  output logic [csf_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [csf_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [csf_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  assign s_awready = !aw_held_reg && !s_bvalid;
  assign s_wready = !w_held_reg && !s_bvalid;
  assign wr_en = aw_held_reg && w_held_reg && !s_bvalid;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;
  assign wr_strb = w_strb_reg;
  assign s_arready = !s_rvalid;
  assign rd_addr = s_araddr;

  // ****************************************
  // Write path
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_bvalid <= 1'b0;
      s_bresp <= csf_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
      if (wr_en)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? csf_pkg::RESP_OKAY : csf_pkg::RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= csf_pkg::RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_data;
      s_rresp <= rd_ok ? csf_pkg::RESP_OKAY : csf_pkg::RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
      s_rvalid <= 1'b0;
  end
endmodule

// ===== verilog/csf_status_word.sv
// Processor status word with datapath update port and AXI4-Lite register access.
// Assumes datapath strobes are synchronous one-cycle pulses on aclk.
`timescale 1ns/1ps
// Summary of operation
// - Bit 15 flags accumulator A overflow.
// - Bit 14 flags accumulator B overflow.
// - Clip flags written directly or cleared together.
// - Priority level is control bit plus three.
// - Top priority bit blocks user interrupts.
// - Nesting disable makes the three status priority bits read-only.
module csf_status_word
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [csf_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [csf_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Datapath flag inputs
  input wire logic acc_a_ovf_in,
  input wire logic acc_b_ovf_in,
  input wire logic acc_a_clip_in,
  input wire logic acc_b_clip_in,
  input wire logic loop_active_in,
  input wire logic repeat_active_in,
  input wire logic alu_flags_we,
  input wire logic half_carry_in,
  input wire logic [3:0] alu_flags_in,
  // Priority and status word outputs
  output logic [3:0] cpu_priority_level,
  output logic user_int_blocked,
  output logic [15:0] cpu_status_word,
  // Interrupt
  output logic irq
);
  logic wr_en;
  logic [csf_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [csf_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  logic acc_a_overflow_flag_reg;
  logic acc_b_overflow_flag_reg;
  logic acc_a_clip_sticky_reg;
  logic acc_b_clip_sticky_reg;
  logic half_carry_reg;
  logic [2:0] prio_low_reg;
  logic [3:0] alu_flags_reg;
  logic [15:0] core_control_word_reg;
  logic [15:0] int_control_one_reg;
  logic [csf_pkg::EVT_W-1:0] evt_status_reg;
  logic [csf_pkg::EVT_W-1:0] evt_mask_reg;
  logic any_acc_overflow;
  logic any_clip_sticky;
  logic nesting_disable;
  logic wr_status_lo;
  logic wr_status_hi;
  logic [csf_pkg::EVT_W-1:0] evt_in;

  csf_axil_slave u_bus
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ****************************************
  // Derived flags
  // ****************************************
  assign any_acc_overflow = acc_a_overflow_flag_reg | acc_b_overflow_flag_reg;
  assign any_clip_sticky = acc_a_clip_sticky_reg | acc_b_clip_sticky_reg;
  assign nesting_disable = int_control_one_reg[csf_pkg::BIT_NEST_DIS];
  assign cpu_priority_level = {core_control_word_reg[csf_pkg::BIT_CORE_PRIO3],
    prio_low_reg};
  assign user_int_blocked = core_control_word_reg[csf_pkg::BIT_CORE_PRIO3];
  assign wr_status_lo = wr_en && wr_addr == csf_pkg::ADDR_STATUS && wr_strb[0];
  assign wr_status_hi = wr_en && wr_addr == csf_pkg::ADDR_STATUS && wr_strb[1];

  always_comb
  begin
    cpu_status_word = csf_pkg::STATUS_RESET;
    cpu_status_word[csf_pkg::BIT_OVF_A] = acc_a_overflow_flag_reg;
    cpu_status_word[csf_pkg::BIT_OVF_B] = acc_b_overflow_flag_reg;
    cpu_status_word[csf_pkg::BIT_CLIP_A] = acc_a_clip_sticky_reg;
    cpu_status_word[csf_pkg::BIT_CLIP_B] = acc_b_clip_sticky_reg;
    cpu_status_word[csf_pkg::BIT_ANY_OVF] = any_acc_overflow;
    cpu_status_word[csf_pkg::BIT_ANY_CLIP] = any_clip_sticky;
    cpu_status_word[csf_pkg::BIT_LOOP] = loop_active_in;
    cpu_status_word[csf_pkg::BIT_HALF_CARRY] = half_carry_reg;
    cpu_status_word[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO] = prio_low_reg;
    cpu_status_word[csf_pkg::BIT_REPEAT] = repeat_active_in;
    cpu_status_word[csf_pkg::BIT_ALU_HI:csf_pkg::BIT_ALU_LO] = alu_flags_reg;
  end

  // ****************************************
  // Overflow flags follow the datapath
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_a_overflow_flag_reg <= 1'b0;
      acc_b_overflow_flag_reg <= 1'b0;
    end
    else
    begin
      acc_a_overflow_flag_reg <= acc_a_ovf_in;
      acc_b_overflow_flag_reg <= acc_b_ovf_in;
    end
  end

  // ****************************************
  // Sticky clip flags: datapath set wins over software
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_a_clip_sticky_reg <= 1'b0;
      acc_b_clip_sticky_reg <= 1'b0;
    end
    else
    begin
      if (wr_status_hi)
      begin
        if (!wr_data[csf_pkg::BIT_ANY_CLIP])
        begin
          acc_a_clip_sticky_reg <= acc_a_clip_in;
          acc_b_clip_sticky_reg <= acc_b_clip_in;
        end
        else
        begin
          acc_a_clip_sticky_reg <= wr_data[csf_pkg::BIT_CLIP_A] | acc_a_clip_in;
          acc_b_clip_sticky_reg <= wr_data[csf_pkg::BIT_CLIP_B] | acc_b_clip_in;
        end
      end
      else
      begin
        acc_a_clip_sticky_reg <= acc_a_clip_sticky_reg | acc_a_clip_in;
        acc_b_clip_sticky_reg <= acc_b_clip_sticky_reg | acc_b_clip_in;
      end
    end
  end

  // ****************************************
  // Half carry, ALU flags and priority bits
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      half_carry_reg <= 1'b0;
      alu_flags_reg <= '0;
      prio_low_reg <= '0;
    end
    else
    begin
      if (alu_flags_we)
      begin
        half_carry_reg <= half_carry_in;
        alu_flags_reg <= alu_flags_in;
      end
      else
      begin
        if (wr_status_hi)
          half_carry_reg <= wr_data[csf_pkg::BIT_HALF_CARRY];
        if (wr_status_lo)
          alu_flags_reg <= wr_data[csf_pkg::BIT_ALU_HI:csf_pkg::BIT_ALU_LO];
      end
      if (wr_status_lo && !nesting_disable)
        prio_low_reg <= wr_data[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO];
    end
  end

  // ****************************************
  // Control words
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_control_word_reg <= csf_pkg::CTRL_RESET;
      int_control_one_reg <= csf_pkg::CTRL_RESET;
      evt_mask_reg <= csf_pkg::EVT_RESET;
    end
    else if (wr_en)
    begin
      if (wr_addr == csf_pkg::ADDR_CORE_CTRL)
      begin
        if (wr_strb[0])
          core_control_word_reg[7:0] <= wr_data[7:0];
        if (wr_strb[1])
          core_control_word_reg[15:8] <= wr_data[15:8];
      end
      if (wr_addr == csf_pkg::ADDR_INT_CTRL)
      begin
        if (wr_strb[0])
          int_control_one_reg[7:0] <= wr_data[7:0];
        if (wr_strb[1])
          int_control_one_reg[15:8] <= wr_data[15:8];
      end
      if (wr_addr == csf_pkg::ADDR_EVT_MASK && wr_strb[0])
        evt_mask_reg <= wr_data[csf_pkg::EVT_W-1:0];
    end
  end

  // ****************************************
  // Event status, write one to clear, set wins
  // ****************************************
  assign evt_in = {acc_b_clip_in, acc_a_clip_in, acc_b_ovf_in, acc_a_ovf_in};

  generate
    for (genvar i = 0; i < csf_pkg::EVT_W; i++)
    begin : g_evt
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          evt_status_reg[i] <= 1'b0;
        else if (evt_in[i])
          evt_status_reg[i] <= 1'b1;
        else if (wr_en && wr_addr == csf_pkg::ADDR_EVT_STATUS && wr_strb[0] && wr_data[i])
          evt_status_reg[i] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(evt_status_reg & evt_mask_reg);

  // ****************************************
  // Register decode
  // ****************************************
  always_comb
  begin
    wr_ok = 1'b1;
    case (wr_addr)
      csf_pkg::ADDR_STATUS, csf_pkg::ADDR_CORE_CTRL, csf_pkg::ADDR_INT_CTRL,
      csf_pkg::ADDR_EVT_STATUS, csf_pkg::ADDR_EVT_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_data = '0;
    rd_ok = 1'b1;
    case (rd_addr)
      csf_pkg::ADDR_STATUS: rd_data = {16'h0000, cpu_status_word};
      csf_pkg::ADDR_CORE_CTRL: rd_data = {16'h0000, core_control_word_reg};
      csf_pkg::ADDR_INT_CTRL: rd_data = {16'h0000, int_control_one_reg};
      csf_pkg::ADDR_EVT_STATUS: rd_data = {28'h0000000, evt_status_reg};
      csf_pkg::ADDR_EVT_MASK: rd_data = {28'h0000000, evt_mask_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_ovf_a_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_a_ovf_in |=> cpu_status_word[csf_pkg::BIT_OVF_A])
    else $error("overflow A flag not set");
  chk_ovf_b_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    !acc_b_ovf_in |=> !cpu_status_word[csf_pkg::BIT_OVF_B])
    else $error("overflow B flag set without cause");
  chk_clip_clear_all: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_status_hi && !wr_data[csf_pkg::BIT_ANY_CLIP] && !acc_a_clip_in && !acc_b_clip_in
    |=> !any_clip_sticky)
    else $error("combined clip clear failed");
  chk_prio_compose: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_status_lo && !nesting_disable
    |=> cpu_priority_level[2:0] == $past(wr_data[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO]))
    else $error("priority level mismatch");
  chk_user_block: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_addr == csf_pkg::ADDR_CORE_CTRL && wr_strb[0]
    |=> user_int_blocked == $past(wr_data[csf_pkg::BIT_CORE_PRIO3]))
    else $error("user interrupts not blocked");
  chk_prio_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    nesting_disable |=> $stable(prio_low_reg))
    else $error("priority bits changed while locked");
  chk_any_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(acc_a_ovf_in) || $past(acc_b_ovf_in) |-> cpu_status_word[csf_pkg::BIT_ANY_OVF])
    else $error("combined overflow missing");
  chk_clip_sticky_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_a_clip_in |=> any_clip_sticky[*1] ##0 acc_a_clip_sticky_reg)
    else $error("clip sticky lost");
endmodule

// ===== tb/csf_dp_model.sv
// Behavioural model of the accumulator and ALU datapath feeding the status word.
// Assumes one bench command at a time, sampled at the rising edge of aclk.
`timescale 1ns/1ps
module csf_dp_model
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench commands
  input wire logic cmd_go,
  input wire logic [2:0] cmd,
  // Datapath flags
  output logic acc_a_ovf_in,
  output logic acc_b_ovf_in,
  output logic acc_a_clip_in,
  output logic acc_b_clip_in,
  output logic loop_active_in,
  output logic repeat_active_in,
  output logic alu_flags_we,
  output logic half_carry_in,
  output logic [3:0] alu_flags_in
);
  // ********
  // Flag sources
  // ********
  always_ff @(posedge aclk)
  begin
    acc_a_clip_in <= 1'b0;
    acc_b_clip_in <= 1'b0;
    alu_flags_we <= 1'b0;
    if (!aresetn)
    begin
      {acc_a_ovf_in, acc_b_ovf_in} <= 2'h0;
      {loop_active_in, repeat_active_in} <= 2'h0;
      {half_carry_in, alu_flags_in} <= 5'h00;
    end
    else if (cmd_go)
    begin
      case (cmd)
        3'h0: acc_a_ovf_in <= 1'b1;
        3'h1: acc_b_ovf_in <= 1'b1;
        3'h2: {acc_a_ovf_in, acc_b_ovf_in} <= 2'h0;
        3'h3: acc_a_clip_in <= 1'b1;
        3'h4: acc_b_clip_in <= 1'b1;
        3'h5: {loop_active_in, repeat_active_in} <= 2'h3;
        default:
        begin
          alu_flags_we <= 1'b1;
          {half_carry_in, alu_flags_in} <= 5'h1A;
        end
      endcase
    end
  end
endmodule

// ===== tb/cpu_status_flags_register_tb_top.sv
// Self-checking bench for the status word block driven over AXI4-Lite.
// Assumes the datapath model in csf_dp_model; only the watchdog bounds a bus wait.
`timescale 1ns/1ps
module cpu_status_flags_register_tb_top;
  // ********
  // Signals
  // ********
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, rdat;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, user_int_blocked;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [3:0] cpu_priority_level, alu_flags_in;
  logic [15:0] cpu_status_word;
  logic acc_a_ovf_in, acc_b_ovf_in, acc_a_clip_in, acc_b_clip_in, loop_active_in;
  logic repeat_active_in, alu_flags_we, half_carry_in;
  logic cmd_go = 1'b0;
  logic [2:0] cmd = 3'h0;
  int err_count = 0;
  int samples_checked = 0;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e; logic [1:0] r;
    logic [3:0] p; logic b;} csf_row_s;
  csf_row_s rows [9] = '{
    '{csf_pkg::ADDR_STATUS, 16'hC0E0, 16'h00E0, csf_pkg::RESP_OKAY, 4'h7, 1'b0},
    '{csf_pkg::ADDR_CORE_CTRL, 16'h0008, 16'h0008, csf_pkg::RESP_OKAY, 4'hF, 1'b1},
    '{csf_pkg::ADDR_CORE_CTRL, 16'h0000, 16'h0000, csf_pkg::RESP_OKAY, 4'h7, 1'b0},
    '{csf_pkg::ADDR_INT_CTRL, 16'h8000, 16'h8000, csf_pkg::RESP_OKAY, 4'h7, 1'b0},
    '{csf_pkg::ADDR_STATUS, 16'h0040, 16'h00E0, csf_pkg::RESP_OKAY, 4'h7, 1'b0},
    '{csf_pkg::ADDR_INT_CTRL, 16'h0000, 16'h0000, csf_pkg::RESP_OKAY, 4'h7, 1'b0},
    '{csf_pkg::ADDR_STATUS, 16'h0040, 16'h0040, csf_pkg::RESP_OKAY, 4'h2, 1'b0},
    '{csf_pkg::ADDR_EVT_MASK, 16'h000F, 16'h000F, csf_pkg::RESP_OKAY, 4'h2, 1'b0},
    '{8'h14, 16'h1234, 16'h0000, csf_pkg::RESP_SLVERR, 4'h2, 1'b0}};

  always #5 aclk = ~aclk;

  csf_status_word csf_status_word_inst
  (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .acc_a_ovf_in, .acc_b_ovf_in,
    .acc_a_clip_in, .acc_b_clip_in, .loop_active_in, .repeat_active_in, .alu_flags_we,
    .half_carry_in, .alu_flags_in, .cpu_priority_level, .user_int_blocked,
    .cpu_status_word, .irq
  );

  csf_dp_model csf_dp_model_inst
  (
    .aclk, .aresetn, .cmd_go, .cmd, .acc_a_ovf_in, .acc_b_ovf_in, .acc_a_clip_in,
    .acc_b_clip_in, .loop_active_in, .repeat_active_in, .alu_flags_we, .half_carry_in,
    .alu_flags_in
  );

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      samples_checked++;
      if (g !== e)
      begin
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        err_count++;
      end
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    logic b;
    begin
      b = 1'b0;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!b)
      begin
        #1;
        aw = s_awvalid & s_awready;
        w = s_wvalid & s_wready;
        b = s_bvalid & s_bready;
        r = s_bresp;
        @(posedge aclk);
        if (aw)
          s_awvalid <= 1'b0;
        if (w)
          s_wvalid <= 1'b0;
        if (b)
          s_bready <= 1'b0;
      end
      #1;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    logic rv;
    begin
      rv = 1'b0;
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      while (!rv)
      begin
        #1;
        ar = s_arvalid & s_arready;
        rv = s_rvalid & s_rready;
        d = s_rdata;
        r = s_rresp;
        @(posedge aclk);
        if (ar)
          s_arvalid <= 1'b0;
        if (rv)
          s_rready <= 1'b0;
      end
      #1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    begin
      axi_wr(a, {16'h0000, d}, resp);
      chk(resp, csf_pkg::RESP_OKAY);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    begin
      axi_rd(a, rdat, resp);
      chk(rdat, {16'h0000, e});
      if (a == csf_pkg::ADDR_STATUS)
        chk(cpu_status_word, e);
    end
  endtask

  task automatic dp(input logic [2:0] c);
    begin
      cmd <= c;
      cmd_go <= 1'b1;
      @(posedge aclk);
      cmd_go <= 1'b0;
      repeat (2) @(posedge aclk);
      #1;
    end
  endtask

  task automatic summarize;
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    foreach (rows[i])
    begin
      axi_wr(rows[i].a, {16'h0000, rows[i].d}, resp);
      chk(resp, rows[i].r);
      axi_rd(rows[i].a, rdat, resp);
      chk(rdat, {16'h0000, rows[i].e});
      chk(resp, rows[i].r);
      chk(cpu_priority_level, rows[i].p);
      chk(user_int_blocked, rows[i].b);
    end
    $display("table test done");
    dp(3'h0);
    rd(csf_pkg::ADDR_STATUS, 16'h8840);
    chk(irq, 1'b1);
    rd(csf_pkg::ADDR_EVT_STATUS, 16'h0001);
    dp(3'h2);
    rd(csf_pkg::ADDR_STATUS, 16'h0040);
    wr(csf_pkg::ADDR_EVT_STATUS, 16'h0001);
    chk(irq, 1'b0);
    wr(csf_pkg::ADDR_EVT_MASK, 16'h0000);
    dp(3'h1);
    rd(csf_pkg::ADDR_STATUS, 16'h4840);
    chk(irq, 1'b0);
    dp(3'h2);
    rd(csf_pkg::ADDR_STATUS, 16'h0040);
    wr(csf_pkg::ADDR_EVT_MASK, 16'h0002);
    chk(irq, 1'b1);
    wr(csf_pkg::ADDR_EVT_STATUS, 16'h0002);
    chk(irq, 1'b0);
    $display("overflow test done");
    dp(3'h3);
    rd(csf_pkg::ADDR_STATUS, 16'h2440);
    dp(3'h4);
    rd(csf_pkg::ADDR_STATUS, 16'h3440);
    chk(irq, 1'b0);
    wr(csf_pkg::ADDR_STATUS, 16'h3040);
    rd(csf_pkg::ADDR_STATUS, 16'h0040);
    wr(csf_pkg::ADDR_STATUS, 16'h2440);
    rd(csf_pkg::ADDR_STATUS, 16'h2440);
    wr(csf_pkg::ADDR_STATUS, 16'h1440);
    rd(csf_pkg::ADDR_STATUS, 16'h1440);
    dp(3'h5);
    dp(3'h6);
    rd(csf_pkg::ADDR_STATUS, 16'h175A);
    rd(csf_pkg::ADDR_EVT_STATUS, 16'h000C);
    chk(irq, 1'b0);
    $display("sticky test done");
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    for (int k = 0; k < 5; k++)
      rd(8'(4 * k), 16'h0000);
    chk(cpu_priority_level, 4'h0);
    chk(irq, 1'b0);
    $display("reset test done");
    summarize();
  end

  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
endmodule
